/* File: cpa_defines.svh */
`ifndef CPA_DEFINES_SVH
`define CPA_DEFINES_SVH

// Register indices; byte address is four times the index
`define CPA_IDX_W          6
`define CPA_IDX_PIN_IN     6'h00
`define CPA_IDX_MODE       6'h02
`define CPA_IDX_OUT_LATCH  6'h04
`define CPA_IDX_DIR        6'h06
`define CPA_IDX_DRIVE      6'h08
`define CPA_IDX_MC_IN      6'h0a
`define CPA_IDX_OE_STAT    6'h0c

// Byte-address field holding the index
`define CPA_ADDR_IDX_LSB   2
`define CPA_ADDR_IDX_MSB   7

// Reset values
`define CPA_RST_MODE       8'h00
`define CPA_RST_OUT_LATCH  8'h00
`define CPA_RST_DIR        8'h00
`define CPA_RST_DRIVE      8'h00
`define CPA_RST_MC         8'h00
`define CPA_RST_RDATA      32'h0000_0000

`endif

/* File: cpa_pkg.sv */
package cpa_pkg;

   typedef enum logic [3:0] {
      CPA_ST_IDLE  = 4'b0001,
      CPA_ST_WDATA = 4'b0010,
      CPA_ST_RWAIT = 4'b0100,
      CPA_ST_RDATA = 4'b1000
   } cpa_bus_st_t;

   typedef logic [7:0] cpa_byte_t;

endpackage

/* File: cpa_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a change counts once stages two and three agree
module cpa_pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] pin_o
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_q;
   logic [WIDTH-1:0] out_d;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         assign out_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : out_q[gi];
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= pin_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign pin_o = out_q;

endmodule

`default_nettype wire

/* File: cpa_port_regs.sv */
// What this block does
// - The output-latch register stores written data, drives it out in I/O output mode, resets to 0.
// - Each direction bit makes its pin an input at 0 and an output at 1 while its mode bit is 0 (mode 1 forces output); resets to 0.
// - Each drive bit selects push-pull at 0 and open-drain at 1; resets to 0.
// - Reading the macrocell-input register returns the input macrocell latches, not live pins.
// - Reading the output-enable status register returns each driver's enable, 0 meaning input or an open-drain pin released at 1.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cpa_defines.svh"

module cpa_port_regs
   import cpa_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             hsel_i,
   input  wire logic [31:0]      haddr_i,
   input  wire logic [1:0]       htrans_i,
   input  wire logic             hwrite_i,
   input  wire logic [2:0]       hsize_i,
   input  wire logic [31:0]      hwdata_i,
   input  wire logic             hready_i,
   output logic      [31:0]      hrdata_o,
   output logic                  hreadyout_o,
   output logic                  hresp_o,
   input  wire logic [WIDTH-1:0] pad_in_i,
   output logic      [WIDTH-1:0] pad_out_o,
   output logic      [WIDTH-1:0] pad_oe_o,
   output logic      [WIDTH-1:0] pad_drive_type_o,
   input  wire logic [WIDTH-1:0] addr_out_i,
   input  wire logic [WIDTH-1:0] mc_load_i
);

   // Matches a captured word index against a register index
   function automatic logic idx_hit(input logic [`CPA_IDX_W-1:0] idx,
                                    input logic [`CPA_IDX_W-1:0] reg_idx);
      idx_hit = (idx == reg_idx);
   endfunction

   cpa_bus_st_t              st_q;
   cpa_bus_st_t              st_d;
   logic [`CPA_IDX_W-1:0]    idx_q;
   logic [31:0]              rdata_q;
   logic [WIDTH-1:0]         mode_q;
   logic [WIDTH-1:0]         latch_q;
   logic [WIDTH-1:0]         dir_q;
   logic [WIDTH-1:0]         drv_q;
   logic [WIDTH-1:0]         mc_q;
   logic [WIDTH-1:0]         pin_out_q;
   logic [WIDTH-1:0]         pin_oe_q;
   logic [WIDTH-1:0]         pin_sync;
   logic [WIDTH-1:0]         mc_d;
   logic [WIDTH-1:0]         out_val;
   logic [WIDTH-1:0]         oe_val;
   logic [WIDTH-1:0]         wbyte;
   logic [WIDTH-1:0]         rd_byte;
   logic [`CPA_IDX_W-1:0]    addr_idx;
   wire                      accept;
   wire                      wr_now;
   wire                      we_mode;
   wire                      we_latch;
   wire                      we_dir;
   wire                      we_drv;

   cpa_pin_sync #(
      .WIDTH (WIDTH)
   ) u_sync (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .pin_i  (pad_in_i),
      .pin_o  (pin_sync)
   );

   // Bus decode; base selection arrives on hsel
   assign addr_idx = haddr_i[`CPA_ADDR_IDX_MSB:`CPA_ADDR_IDX_LSB];
   assign accept   = hsel_i & htrans_i[1] & hready_i;
   assign wr_now   = (st_q == CPA_ST_WDATA);
   assign wbyte    = hwdata_i[WIDTH-1:0];
   assign we_mode  = wr_now & idx_hit(idx_q, `CPA_IDX_MODE);
   assign we_latch = wr_now & idx_hit(idx_q, `CPA_IDX_OUT_LATCH);
   assign we_dir   = wr_now & idx_hit(idx_q, `CPA_IDX_DIR);
   assign we_drv   = wr_now & idx_hit(idx_q, `CPA_IDX_DRIVE);

   always_comb begin
      st_d = CPA_ST_IDLE;
      case (st_q)
         CPA_ST_RWAIT: begin
            st_d = CPA_ST_RDATA;
         end
         CPA_ST_IDLE, CPA_ST_WDATA, CPA_ST_RDATA: begin
            if (accept) begin
               st_d = hwrite_i ? CPA_ST_WDATA : CPA_ST_RWAIT;
            end
         end
         default: begin
            st_d = CPA_ST_IDLE;
         end
      endcase
   end

   // Read selection; unmapped offsets read zero
   always_comb begin
      rd_byte = '0;
      case (idx_q)
         `CPA_IDX_PIN_IN:    rd_byte = pin_sync;
         `CPA_IDX_MODE:      rd_byte = mode_q;
         `CPA_IDX_OUT_LATCH: rd_byte = latch_q;
         `CPA_IDX_DIR:       rd_byte = dir_q;
         `CPA_IDX_DRIVE:     rd_byte = drv_q;
         `CPA_IDX_MC_IN:     rd_byte = mc_q;
         `CPA_IDX_OE_STAT:   rd_byte = pin_oe_q;
         default:            rd_byte = '0;
      endcase
   end

   // Pin driver: address output overrides the latch, open drain only pulls low
   assign out_val = (mode_q & addr_out_i) | (~mode_q & latch_q);
   assign oe_val  = (mode_q | dir_q) & ~(drv_q & out_val);
   assign mc_d    = (mc_load_i & pin_sync) | (~mc_load_i & mc_q);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q  <= CPA_ST_IDLE;
         idx_q <= '0;
      end else begin
         st_q <= st_d;
         if (accept) begin
            idx_q <= addr_idx;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= `CPA_RST_RDATA;
      end else if (st_q == CPA_ST_RWAIT) begin
         rdata_q <= {{(32-WIDTH){1'b0}}, rd_byte};
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_q  <= `CPA_RST_MODE;
         latch_q <= `CPA_RST_OUT_LATCH;
         dir_q   <= `CPA_RST_DIR;
         drv_q   <= `CPA_RST_DRIVE;
      end else begin
         if (we_mode) begin
            mode_q <= wbyte;
         end
         if (we_latch) begin
            latch_q <= wbyte;
         end
         if (we_dir) begin
            dir_q <= wbyte;
         end
         if (we_drv) begin
            drv_q <= wbyte;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mc_q      <= `CPA_RST_MC;
         pin_out_q <= '0;
         pin_oe_q  <= '0;
      end else begin
         mc_q      <= mc_d;
         pin_out_q <= out_val;
         pin_oe_q  <= oe_val;
      end
   end

   assign hrdata_o         = rdata_q;
   assign hreadyout_o      = (st_q != CPA_ST_RWAIT);
   assign hresp_o          = 1'b0;
   assign pad_out_o        = pin_out_q;
   assign pad_oe_o         = pin_oe_q;
   assign pad_drive_type_o = drv_q;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   property p_latch_wr;
      (st_q == CPA_ST_WDATA) && (idx_q == `CPA_IDX_OUT_LATCH)
         |=> latch_q == $past(hwdata_i[WIDTH-1:0]);
   endproperty
   a_latch_wr: assert property (p_latch_wr) else $error("latch write lost");

   property p_pin_drive;
      (mode_q == '0) && (dir_q == '1) && (drv_q == '0)
         ##1 $stable(latch_q) && $stable(dir_q) && $stable(mode_q) && $stable(drv_q)
         |=> (pad_out_o == $past(latch_q, 2)) && (pad_oe_o == '1);
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("latch not on pins");

   property p_dir_in;
      (!dir_q[0] && !mode_q[0]) |=> !pad_oe_o[0];
   endproperty
   a_dir_in: assert property (p_dir_in) else $error("input pin driven");

   property p_od_high;
      (drv_q[0] && out_val[0]) |=> !pad_oe_o[0];
   endproperty
   a_od_high: assert property (p_od_high) else $error("open drain drove high");

   property p_mc_read;
      (st_q == CPA_ST_RWAIT) && (idx_q == `CPA_IDX_MC_IN)
         |=> hreadyout_o && (hrdata_o == {24'h000000, $past(mc_q)});
   endproperty
   a_mc_read: assert property (p_mc_read) else $error("macrocell readback wrong");

   property p_oe_read;
      (st_q == CPA_ST_RWAIT) && (idx_q == `CPA_IDX_OE_STAT)
         |=> hrdata_o[WIDTH-1:0] == $past(pad_oe_o);
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("enable status wrong");

   property p_pin_read;
      (st_q == CPA_ST_RWAIT) && (idx_q == `CPA_IDX_PIN_IN)
         |=> hrdata_o[WIDTH-1:0] == $past(pin_sync);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin readback wrong");

   property p_addr_mode;
      (mode_q == '1) |=> pad_out_o == $past(addr_out_i);
   endproperty
   a_addr_mode: assert property (p_addr_mode) else $error("address not on pins");

   property p_rd_wait;
      accept && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

   property p_wr_zero_wait;
      accept && hwrite_i |=> hreadyout_o;
   endproperty
   a_wr_zero_wait: assert property (p_wr_zero_wait) else $error("write data phase stalled");

   // All mapped indices are even, so an odd index is unmapped
   property p_unmapped_rd;
      (st_q == CPA_ST_RWAIT) && idx_q[0]
         |=> hrdata_o == '0;
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

   property p_unmapped_wr;
      wr_now && idx_q[0]
         |=> $stable(mode_q) && $stable(latch_q) && $stable(dir_q) && $stable(drv_q);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write changed state");

   property p_mode_wr;
      (st_q == CPA_ST_WDATA) && (idx_q == `CPA_IDX_MODE)
         |=> mode_q == $past(hwdata_i[WIDTH-1:0]);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");

   property p_dir_wr;
      (st_q == CPA_ST_WDATA) && (idx_q == `CPA_IDX_DIR)
         |=> dir_q == $past(hwdata_i[WIDTH-1:0]);
   endproperty
   a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");

   property p_drv_wr;
      (st_q == CPA_ST_WDATA) && (idx_q == `CPA_IDX_DRIVE)
         |=> drv_q == $past(hwdata_i[WIDTH-1:0]);
   endproperty
   a_drv_wr: assert property (p_drv_wr) else $error("drive write lost");

   property p_mode_hold;
      !we_mode |=> $stable(mode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed unasked");

   property p_latch_hold;
      !we_latch |=> $stable(latch_q);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed unasked");

   property p_rd_hold;
      (st_q != CPA_ST_RWAIT) |=> $stable(hrdata_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data did not stand");

   c_write:   cover property (accept && hwrite_i ##1 wr_now);
   c_read:    cover property (accept && !hwrite_i ##2 hreadyout_o);
   c_addr:    cover property (mode_q != '0);
   c_od:      cover property ((drv_q & dir_q) != '0);
   c_mc_load: cover property (mc_load_i != '0);

endmodule

`default_nettype wire

/* File: cpa_pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// Outside world on the port lines; pull-ups and far drivers win where the port is off
module cpa_pin_partner (
   input  wire logic [7:0] pad_out_i,
   input  wire logic [7:0] pad_oe_i,
   input  wire logic [7:0] ext_level_i,
   output logic      [7:0] wire_o
);
   assign wire_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);
endmodule

`default_nettype wire

/* File: test_config_port_a_registers.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpa_defines.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("BAD %0t got %h exp %h", $time, a, e); end end

module test_config_port_a_registers;
   import cpa_pkg::*;
   logic        clk_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0, rd_dp = 0;
   logic        hreadyout_o, hresp_o;
   logic [1:0]  htrans_i = 2'h0;
   logic [2:0]  hsize_i = 3'h2;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, e_q;
   logic [31:0] lfsr = 32'h8eb6ef99;
   logic [31:0] expq[$];
   cpa_byte_t   pad_out_o, pad_oe_o, pad_drive_type_o, pin_w;
   cpa_byte_t   ext = 8'h5a, addr_out_i = 8'h00, mc_load_i = 8'h00;
   cpa_byte_t   mode, latch, dir, drv, oe, outv, lvl;
   int          n_errors = 0, n_checks = 0, cyc = 0;

   cpa_port_regs #(.WIDTH(8)) cpa_port_regs_i (
      .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pad_in_i(pin_w),
      .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
      .pad_drive_type_o(pad_drive_type_o), .addr_out_i(addr_out_i),
      .mc_load_i(mc_load_i));

   cpa_pin_partner cpa_pin_partner_i (
      .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_level_i(ext), .wire_o(pin_w));

   initial forever #4 clk_i = ~clk_i;

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic conclude();
      if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         conclude();
      end
   end

   // Read data is settled by mid-cycle of the ready data phase
   always @(negedge clk_i) begin
      if (rd_dp && hreadyout_o === 1'b1) begin
         e_q = expq.pop_front();
         `CHK(hrdata_o, e_q)
         `CHK(hresp_o, 1'b0)
      end
   end

   task automatic wait_rdy();
      logic r;
      do begin
         @(negedge clk_i);
         r = hreadyout_o;
         @(posedge clk_i);
      end while (r !== 1'b1);
   endtask

   task automatic addr_ph(input logic [5:0] idx, input logic w);
      hsel_i   <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      haddr_i  <= {24'h0, idx, 2'h0};
      wait_rdy();
      hsel_i   <= 1'b0;
      htrans_i <= 2'h0;
   endtask

   task automatic wr(input logic [5:0] idx, input cpa_byte_t d);
      addr_ph(idx, 1'b1);
      hwdata_i <= {24'h0, d};
      wait_rdy();
   endtask

   task automatic rd(input logic [5:0] idx, input cpa_byte_t e);
      expq.push_back({24'h0, e});
      addr_ph(idx, 1'b0);
      rd_dp <= 1'b1;
      wait_rdy();
      rd_dp <= 1'b0;
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      // Reset values, then an unmapped slot that ignores writes
      rd(`CPA_IDX_MODE, 8'h00);
      rd(`CPA_IDX_OUT_LATCH, 8'h00);
      rd(`CPA_IDX_DIR, 8'h00);
      rd(`CPA_IDX_DRIVE, 8'h00);
      rd(`CPA_IDX_MC_IN, 8'h00);
      rd(`CPA_IDX_OE_STAT, 8'h00);
      rd(`CPA_IDX_PIN_IN, ext);
      wr(6'h01, 8'hff);
      rd(6'h01, 8'h00);
      for (int i = 0; i < 24; i++) begin
         lfsr = nxt(lfsr);
         mode  = (i < 8) ? 8'h00 : lfsr[7:0] & lfsr[13:6];
         latch = lfsr[15:8];
         dir   = lfsr[23:16];
         drv   = lfsr[31:24];
         addr_out_i <= lfsr[11:4];
         ext        <= lfsr[19:12];
         wr(`CPA_IDX_MODE, mode);
         wr(`CPA_IDX_OUT_LATCH, latch);
         wr(`CPA_IDX_DIR, dir);
         wr(`CPA_IDX_DRIVE, drv);
         rd(`CPA_IDX_OUT_LATCH, latch);
         rd(`CPA_IDX_DIR, dir);
         rd(`CPA_IDX_DRIVE, drv);
         rd(`CPA_IDX_MODE, mode);
         outv = (mode & addr_out_i) | (~mode & latch);
         oe   = (mode | dir) & ~(drv & outv);
         lvl  = (oe & outv) | (~oe & ext);
         rd(`CPA_IDX_OE_STAT, oe);
         rd(`CPA_IDX_PIN_IN, lvl);
         @(negedge clk_i);
         `CHK(pad_out_o, outv)
         `CHK(pad_oe_o, oe)
         `CHK(pad_drive_type_o, drv)
         @(posedge clk_i);
      end
      // Every pin pushed from the latch, then from the address source
      wr(`CPA_IDX_MODE, 8'h00);
      wr(`CPA_IDX_DRIVE, 8'h00);
      wr(`CPA_IDX_DIR, 8'hff);
      wr(`CPA_IDX_OUT_LATCH, 8'h3c);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(pad_out_o, 8'h3c)
      `CHK(pad_oe_o, 8'hff)
      @(posedge clk_i);
      wr(`CPA_IDX_MODE, 8'hff);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(pad_out_o, addr_out_i)
      @(posedge clk_i);
      rd(`CPA_IDX_OE_STAT, 8'hff);
      rd(`CPA_IDX_PIN_IN, addr_out_i);
      // Macrocell latches hold once loading stops, live pins move on
      wr(`CPA_IDX_MODE, 8'h00);
      wr(`CPA_IDX_DIR, 8'h00);
      mc_load_i <= 8'hff;
      repeat (6) @(posedge clk_i);
      mc_load_i <= 8'h00;
      lvl = ext;
      @(posedge clk_i);
      ext <= ~lvl;
      repeat (6) @(posedge clk_i);
      rd(`CPA_IDX_MC_IN, lvl);
      rd(`CPA_IDX_PIN_IN, ~lvl);
      // Second reset in mid-run
      wr(`CPA_IDX_DIR, 8'hff);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      rd(`CPA_IDX_DIR, 8'h00);
      @(negedge clk_i);
      `CHK(pad_oe_o, 8'h00)
      conclude();
   end
endmodule

`default_nettype wire
